// ===== src/bb_cfg_pkg.sv
// Purpose: shared constants and carriers for the baseband header-rate and cca config bank
// Assumes: one 25 MHz clock, avalon-mm slave with waitrequest, byte addresses
// Notes: reset values of the code registers follow the usual header codes

package bb_cfg_pkg;

  // ***************************************
  // bus and register map
  // ***************************************
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned REG_W = 8;
  localparam logic [ADDR_W-1:0] OFS_CCA_HI = 8'h30;
  localparam logic [ADDR_W-1:0] OFS_CCA_LO = 8'h34;
  localparam logic [ADDR_W-1:0] OFS_ED_THR = 8'h38;
  localparam logic [ADDR_W-1:0] OFS_SFD_TMR = 8'h3c;
  localparam logic [ADDR_W-1:0] OFS_CODE_1M = 8'h40;
  localparam logic [ADDR_W-1:0] OFS_CODE_2M = 8'h44;
  localparam logic [ADDR_W-1:0] OFS_CODE_5M5 = 8'h48;
  localparam logic [ADDR_W-1:0] OFS_CODE_11M = 8'h4c;
  localparam logic [ADDR_W-1:0] OFS_TX_RATE = 8'h50;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h80;

  // ***************************************
  // fields
  // ***************************************
  localparam int unsigned CCA_THR_W = 15;
  localparam int unsigned CCA_HI_W = 7;
  localparam int unsigned ED_THR_W = 6;
  localparam logic [ED_THR_W-1:0] ED_ALL_ONES = 6'h3f;
  localparam int unsigned RATE_SEL_W = 2;
  localparam int unsigned DELIMITER_SEARCH_TIMER_W = 8;
  localparam int unsigned ST_VALID_BIT = 0;
  localparam int unsigned ST_RATE_LSB = 1;
  localparam int unsigned ST_SEARCH_BIT = 3;
  localparam int unsigned ST_BUSY_BIT = 4;

  // ***************************************
  // reset values
  // ***************************************
  localparam logic [REG_W-1:0] RST_CCA_HI = 8'h00;
  localparam logic [REG_W-1:0] RST_CCA_LO = 8'h00;
  localparam logic [REG_W-1:0] RST_ED_THR = 8'h3f;
  localparam logic [REG_W-1:0] RST_SFD_TMR = 8'h00;
  localparam logic [REG_W-1:0] RST_CODE_1M = 8'h0a;
  localparam logic [REG_W-1:0] RST_CODE_2M = 8'h14;
  localparam logic [REG_W-1:0] RST_CODE_5M5 = 8'h37;
  localparam logic [REG_W-1:0] RST_CODE_11M = 8'h6e;
  localparam logic [REG_W-1:0] RST_TX_RATE = 8'h00;

  // ***************************************
  // timing
  // ***************************************
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned TX_RATE_SETUP_NS = 2000;
  localparam int unsigned TX_RATE_SETUP_CYC =
    (TX_RATE_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ***************************************
  // types
  // ***************************************
  typedef enum logic [0:0] {
    BUS_IDLE = 1'b0,
    BUS_ACK = 1'b1
  } bus_state_t;

  typedef enum logic [0:0] {
    SRCH_IDLE = 1'b0,
    SRCH_RUN = 1'b1
  } srch_state_t;

  typedef struct packed {
    logic [ADDR_W-1:0] address;
    logic read;
    logic write;
    logic [DATA_W-1:0] writedata;
    logic [3:0] byteenable;
  } avl_req_t;

  typedef struct packed {
    logic [DATA_W-1:0] readdata;
    logic waitrequest;
  } avl_rsp_t;

  typedef struct packed {
    logic [REG_W-1:0] cca_hi;
    logic [REG_W-1:0] cca_lo;
    logic [REG_W-1:0] ed_thr;
    logic [REG_W-1:0] sfd_tmr;
    logic [3:0][REG_W-1:0] code;
    logic [REG_W-1:0] tx_rate;
  } cfg_t;

endpackage : bb_cfg_pkg

// ===== src/sfd_search_timer.sv
// Purpose: times the start-frame-delimiter search of one received header
// Assumes: symbol_tick_i pulses once per symbol period
// Notes: a found delimiter in the same cycle as the last tick wins
`timescale 1ns/100ps
`default_nettype none

module sfd_search_timer
  import bb_cfg_pkg::*;
#(
  parameter int unsigned CNT_W = DELIMITER_SEARCH_TIMER_W
) (
  input wire logic clock_i,
  input wire logic reset_n_i,
  input wire logic [CNT_W-1:0] limit_i,
  input wire logic start_i,
  input wire logic symbol_tick_i,
  input wire logic found_i,
  output logic active_o,
  output logic expired_o
);

  srch_state_t st_q, st_d;
  logic [CNT_W:0] cnt_q, cnt_d, cnt_inc;
  logic exp_q, exp_d;

  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    exp_d = 1'b0;
    cnt_inc = cnt_q + {{CNT_W{1'b0}}, 1'b1};
    unique case (st_q)
      SRCH_IDLE: begin
        if (start_i) begin
          st_d = SRCH_RUN;
          cnt_d = '0;
        end
      end
      SRCH_RUN: begin
        if (found_i) begin
          st_d = SRCH_IDLE;
        end else if (start_i) begin
          cnt_d = '0;
        end else if (symbol_tick_i) begin
          cnt_d = cnt_inc;
          if (cnt_inc >= {1'b0, limit_i}) begin
            st_d = SRCH_IDLE;
            exp_d = 1'b1;
          end
        end
      end
    endcase
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_q <= SRCH_IDLE;
      cnt_q <= '0;
      exp_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      exp_q <= exp_d;
    end
  end

  assign active_o = (st_q == SRCH_RUN);
  assign expired_o = exp_q;

  // ***************************************
  // checks
  // ***************************************
  chk_expire_at_limit: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    (active_o && symbol_tick_i && !found_i && !start_i && (cnt_inc >= {1'b0, limit_i}))
      |=> expired_o)
    else $error("search did not expire at the limit");

  chk_expire_ends_run: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    expired_o |-> (!active_o && !$past(found_i)))
    else $error("search still running after expiry");

endmodule : sfd_search_timer

`default_nettype wire

// ===== src/bb_cfg_regs.sv
// Purpose: configuration bank for cca thresholds, delimiter timer and header rate codes
// Assumes: avalon-mm master holds each request until waitrequest is low
// Notes: every access takes two cycles; unmapped reads return zero
//
// Implementation choice: register access over Avalon-MM.
`timescale 1ns/100ps
`default_nettype none

module bb_cfg_regs
  import bb_cfg_pkg::*;
(
  input wire logic clock_i,
  input wire logic reset_n_i,
  input wire avl_req_t avl_i,
  output var avl_rsp_t avl_o,
  input wire logic cca_dwell_i,
  input wire logic [CCA_THR_W-1:0] amplitude_quality_metric_i,
  input wire logic [ED_THR_W-1:0] signal_strength_reading_i,
  output logic [CCA_THR_W-1:0] cca_threshold_o,
  output logic quality_pass_o,
  output logic energy_detect_flag_o,
  output logic cca_busy_o,
  input wire logic header_start_i,
  input wire logic symbol_tick_i,
  input wire logic sfd_found_i,
  output logic sfd_searching_o,
  output logic return_to_acq_o,
  output logic [REG_W-1:0] tx_signal_field_o,
  input wire logic rx_field_strobe_i,
  input wire logic [REG_W-1:0] rx_signal_field_i,
  output logic rx_field_valid_o,
  output logic [RATE_SEL_W-1:0] rx_rate_o
);

  // ***************************************
  // helpers
  // ***************************************
  function automatic logic code_match(
    input logic [3:0][REG_W-1:0] codes,
    input logic [REG_W-1:0] field
  );
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < 4; i++) begin
      if (codes[i] == field) begin
        hit = 1'b1;
      end
    end
    return hit;
  endfunction

  function automatic logic [RATE_SEL_W-1:0] code_index(
    input logic [3:0][REG_W-1:0] codes,
    input logic [REG_W-1:0] field
  );
    logic [RATE_SEL_W-1:0] idx;
    idx = '0;
    // lowest index wins if software loads duplicate codes
    for (int i = 3; i >= 0; i--) begin
      if (codes[i] == field) begin
        idx = RATE_SEL_W'(i);
      end
    end
    return idx;
  endfunction

  // ***************************************
  // bus slave
  // ***************************************
  bus_state_t st_q, st_d;
  cfg_t cfg_q, cfg_d;
  logic [DATA_W-1:0] rdata_q, rdata_d;
  logic req;
  logic wr_fire;
  logic [REG_W-1:0] wbyte;
  logic [REG_W-1:0] status;

  // read and write together is illegal; treated as no request
  assign req = avl_i.read ^ avl_i.write;
  assign wr_fire = (st_q == BUS_ACK) && avl_i.write && !avl_i.read
    && avl_i.byteenable[0];
  assign wbyte = avl_i.writedata[REG_W-1:0];

  always_comb begin
    st_d = st_q;
    unique case (st_q)
      BUS_IDLE: begin
        if (req) begin
          st_d = BUS_ACK;
        end
      end
      BUS_ACK: begin
        st_d = BUS_IDLE;
      end
    endcase
  end

  // read data is captured in the wait cycle so it is stable at the ack edge
  always_comb begin
    rdata_d = rdata_q;
    if (st_q == BUS_IDLE && avl_i.read && !avl_i.write) begin
      rdata_d = '0;
      case (avl_i.address)
        OFS_CCA_HI: rdata_d[REG_W-1:0] = cfg_q.cca_hi;
        OFS_CCA_LO: rdata_d[REG_W-1:0] = cfg_q.cca_lo;
        OFS_ED_THR: rdata_d[REG_W-1:0] = cfg_q.ed_thr;
        OFS_SFD_TMR: rdata_d[REG_W-1:0] = cfg_q.sfd_tmr;
        OFS_CODE_1M: rdata_d[REG_W-1:0] = cfg_q.code[0];
        OFS_CODE_2M: rdata_d[REG_W-1:0] = cfg_q.code[1];
        OFS_CODE_5M5: rdata_d[REG_W-1:0] = cfg_q.code[2];
        OFS_CODE_11M: rdata_d[REG_W-1:0] = cfg_q.code[3];
        OFS_TX_RATE: rdata_d[REG_W-1:0] = cfg_q.tx_rate;
        OFS_STATUS: rdata_d[REG_W-1:0] = status;
        default: rdata_d = '0;
      endcase
    end
  end

  always_comb begin
    cfg_d = cfg_q;
    if (wr_fire) begin
      case (avl_i.address)
        OFS_CCA_HI: cfg_d.cca_hi = wbyte;
        OFS_CCA_LO: cfg_d.cca_lo = wbyte;
        OFS_ED_THR: cfg_d.ed_thr = wbyte;
        OFS_SFD_TMR: cfg_d.sfd_tmr = wbyte;
        OFS_CODE_1M: cfg_d.code[0] = wbyte;
        OFS_CODE_2M: cfg_d.code[1] = wbyte;
        OFS_CODE_5M5: cfg_d.code[2] = wbyte;
        OFS_CODE_11M: cfg_d.code[3] = wbyte;
        OFS_TX_RATE: cfg_d.tx_rate = wbyte;
        default: cfg_d = cfg_q;
      endcase
    end
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_q <= BUS_IDLE;
      rdata_q <= '0;
      cfg_q.cca_hi <= RST_CCA_HI;
      cfg_q.cca_lo <= RST_CCA_LO;
      cfg_q.ed_thr <= RST_ED_THR;
      cfg_q.sfd_tmr <= RST_SFD_TMR;
      cfg_q.code[0] <= RST_CODE_1M;
      cfg_q.code[1] <= RST_CODE_2M;
      cfg_q.code[2] <= RST_CODE_5M5;
      cfg_q.code[3] <= RST_CODE_11M;
      cfg_q.tx_rate <= RST_TX_RATE;
    end else begin
      st_q <= st_d;
      rdata_q <= rdata_d;
      cfg_q <= cfg_d;
    end
  end

  // one continuous assignment drives the whole response struct
  assign avl_o = '{readdata: rdata_q, waitrequest: req && (st_q == BUS_IDLE)};

  // ***************************************
  // clear channel assessment
  // ***************************************
  logic qpass_q, qpass_d;
  logic ed_q, ed_d;
  logic busy_q, busy_d;
  logic ed_enable;

  assign cca_threshold_o = {cfg_q.cca_hi[CCA_HI_W-1:0], cfg_q.cca_lo};
  assign ed_enable = (cfg_q.ed_thr[ED_THR_W-1:0] != ED_ALL_ONES);

  always_comb begin
    qpass_d = qpass_q;
    if (cca_dwell_i) begin
      qpass_d = (amplitude_quality_metric_i >= cca_threshold_o);
    end
    ed_d = ed_enable
      && (signal_strength_reading_i >= cfg_q.ed_thr[ED_THR_W-1:0]);
    busy_d = qpass_d || ed_d;
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      qpass_q <= 1'b0;
      ed_q <= 1'b0;
      busy_q <= 1'b0;
    end else begin
      qpass_q <= qpass_d;
      ed_q <= ed_d;
      busy_q <= busy_d;
    end
  end

  assign quality_pass_o = qpass_q;
  assign energy_detect_flag_o = ed_q;
  assign cca_busy_o = busy_q;

  // ***************************************
  // delimiter search
  // ***************************************
  sfd_search_timer #(
    .CNT_W(DELIMITER_SEARCH_TIMER_W)
  ) u_delimiter_search_timer (
    .clock_i(clock_i),
    .reset_n_i(reset_n_i),
    .limit_i(cfg_q.sfd_tmr),
    .start_i(header_start_i),
    .symbol_tick_i(symbol_tick_i),
    .found_i(sfd_found_i),
    .active_o(sfd_searching_o),
    .expired_o(return_to_acq_o)
  );

  // ***************************************
  // header signalling field
  // ***************************************
  logic [REG_W-1:0] txf_q, txf_d;
  logic rxv_q, rxv_d;
  logic [RATE_SEL_W-1:0] rxr_q, rxr_d;

  always_comb begin
    txf_d = cfg_q.code[cfg_q.tx_rate[RATE_SEL_W-1:0]];
    rxv_d = rxv_q;
    rxr_d = rxr_q;
    if (rx_field_strobe_i) begin
      rxv_d = code_match(cfg_q.code, rx_signal_field_i);
      rxr_d = code_index(cfg_q.code, rx_signal_field_i);
    end else if (header_start_i) begin
      rxv_d = 1'b0;
    end
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      txf_q <= RST_CODE_1M;
      rxv_q <= 1'b0;
      rxr_q <= '0;
    end else begin
      txf_q <= txf_d;
      rxv_q <= rxv_d;
      rxr_q <= rxr_d;
    end
  end

  assign tx_signal_field_o = txf_q;
  assign rx_field_valid_o = rxv_q;
  assign rx_rate_o = rxr_q;

  always_comb begin
    status = '0;
    status[ST_VALID_BIT] = rxv_q;
    status[ST_RATE_LSB +: RATE_SEL_W] = rxr_q;
    status[ST_SEARCH_BIT] = sfd_searching_o;
    status[ST_BUSY_BIT] = busy_q;
  end

  // ***************************************
  // checks
  // ***************************************
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!reset_n_i);

  sequence s_req_start;
    (st_q == BUS_IDLE) && req;
  endsequence

  sequence s_ack;
    !avl_o.waitrequest;
  endsequence

  chk_bus_one_wait: assert property (s_req_start |-> avl_o.waitrequest ##1 s_ack)
    else $error("access did not finish after one wait cycle");

  chk_unmapped_zero: assert property (
    (s_req_start ##0 (avl_i.read && avl_i.address == 8'h54)) |=> (avl_o.readdata == '0))
    else $error("unmapped read not zero");

  chk_no_alias: assert property (
    (wr_fire && avl_i.address == OFS_CODE_1M) |=> $stable(cfg_q.code[1]))
    else $error("code write touched a neighbour");

  chk_thr_upper: assert property (
    (wr_fire && avl_i.address == OFS_CCA_HI)
      |=> (cca_threshold_o[CCA_THR_W-1:REG_W] == $past(wbyte[CCA_HI_W-1:0])))
    else $error("upper threshold bits not from upper byte");

  chk_quality_cmp: assert property (cca_dwell_i |=> (quality_pass_o ==
    ($past(amplitude_quality_metric_i) >= $past(cca_threshold_o))))
    else $error("quality compare wrong");

  chk_ed_disabled: assert property (
    ($past(cfg_q.ed_thr[ED_THR_W-1:0]) == ED_ALL_ONES) |-> !energy_detect_flag_o)
    else $error("energy flag raised while disabled");

  chk_ed_compare: assert property (
    (ed_enable && signal_strength_reading_i >= cfg_q.ed_thr[ED_THR_W-1:0])
      |=> (energy_detect_flag_o && cca_busy_o))
    else $error("energy flag missed");

  chk_tx_select: assert property (
    (wr_fire && avl_i.address == OFS_TX_RATE) |=> ##1
      (tx_signal_field_o == $past(cfg_q.code[wbyte[RATE_SEL_W-1:0]], 2)))
    else $error("tx field does not follow selector");

  chk_upper_inert: assert property (
    (wr_fire && avl_i.address == OFS_TX_RATE
      && wbyte[RATE_SEL_W-1:0] == cfg_q.tx_rate[RATE_SEL_W-1:0]
      && $stable(cfg_q.code)) |=> ##1 $stable(tx_signal_field_o))
    else $error("selector upper bits changed the tx field");

  chk_rx_classify: assert property (rx_field_strobe_i |=> (rx_field_valid_o ==
    $past(code_match(cfg_q.code, rx_signal_field_i))))
    else $error("rx field validity wrong");

  chk_rx_rate: assert property ((rx_field_strobe_i && cfg_q.code[3] == rx_signal_field_i
    && cfg_q.code[0] != rx_signal_field_i && cfg_q.code[1] != rx_signal_field_i
    && cfg_q.code[2] != rx_signal_field_i)
      |=> (rx_rate_o == 2'h3))
    else $error("rx rate index wrong");

endmodule : bb_cfg_regs

`default_nettype wire

// ===== tb/mac_model.sv
// Purpose: controller model that programs the config bank over avalon-mm
// Assumes: slave holds waitrequest high until the access completes
// Notes: the waitrequest wait in bus_access is unbounded; the bench watchdog ends a hang
`timescale 1ns/100ps
`default_nettype none

module mac_model
  import bb_cfg_pkg::*;
(
  input wire logic clock_i,
  input wire avl_rsp_t avl_i,
  output var avl_req_t avl_o
);
  // ***************************************
  // bus cycles
  // ***************************************
  initial begin
    avl_o = '0;
  end

  // request held until the edge that sees waitrequest low, released on that edge
  task automatic bus_access(input logic rd, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] wd,
                            output logic [DATA_W-1:0] rdata);
    @(posedge clock_i);
    avl_o <= '{address: a, read: rd, write: !rd, writedata: wd, byteenable: 4'hf};
    do @(posedge clock_i); while (avl_i.waitrequest !== 1'b0);
    rdata = avl_i.readdata;
    avl_o <= '0;
  endtask

  // ***************************************
  // standard programming
  // ***************************************
  task automatic load_codes();
    logic [DATA_W-1:0] d;
    bus_access(1'b0, OFS_CODE_1M, 32'h0000000a, d);
    bus_access(1'b0, OFS_CODE_2M, 32'h00000014, d);
    bus_access(1'b0, OFS_CODE_5M5, 32'h00000037, d);
    bus_access(1'b0, OFS_CODE_11M, 32'h0000006e, d);
  endtask

  // the rate must settle before the frame uses it
  task automatic set_rate(input logic [REG_W-1:0] v);
    logic [DATA_W-1:0] d;
    bus_access(1'b0, OFS_TX_RATE, {24'h000000, v}, d);
    repeat (TX_RATE_SETUP_CYC) @(posedge clock_i);
  endtask
endmodule // mac_model
`default_nettype wire

// ===== tb/baseband_header_rate_and_cca_config_bench.sv
// Purpose: self-checking bench for the header-rate and cca config bank
// Assumes: two-cycle bus accesses, registered flags one cycle after inputs
// Notes: expectations come from a register array model kept here
`timescale 1ns/100ps
`default_nettype none

module baseband_header_rate_and_cca_config_bench;
  import bb_cfg_pkg::*;
  logic clock_i, reset_n_i, dwell, hdr_start, tick, found, strobe;
  logic [CCA_THR_W-1:0] metric;
  logic [ED_THR_W-1:0] strength;
  logic [REG_W-1:0] rx_field, tx_field;
  logic [CCA_THR_W-1:0] cca_thr;
  logic q_pass, ed_flag, busy, searching, to_acq, rx_valid;
  logic [RATE_SEL_W-1:0] rx_rate;
  avl_req_t req;
  avl_rsp_t rsp;
  int err_count, num_checks;
  logic [31:0] seed;
  logic [REG_W-1:0] mdl [0:8];
  logic [DATA_W-1:0] rd;
  int lim, thr;
  logic qexp;

  bb_cfg_regs dut (.clock_i(clock_i), .reset_n_i(reset_n_i), .avl_i(req), .avl_o(rsp),
    .cca_dwell_i(dwell), .amplitude_quality_metric_i(metric), .signal_strength_reading_i(strength),
    .cca_threshold_o(cca_thr), .quality_pass_o(q_pass), .energy_detect_flag_o(ed_flag),
    .cca_busy_o(busy), .header_start_i(hdr_start), .symbol_tick_i(tick), .sfd_found_i(found),
    .sfd_searching_o(searching), .return_to_acq_o(to_acq), .tx_signal_field_o(tx_field),
    .rx_field_strobe_i(strobe), .rx_signal_field_i(rx_field), .rx_field_valid_o(rx_valid),
    .rx_rate_o(rx_rate));
  mac_model mac (.clock_i(clock_i), .avl_i(rsp), .avl_o(req));

  // ***************************************
  // helpers
  // ***************************************
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [7:0] rnd();
    seed = lfsr(seed);
    return seed[7:0];
  endfunction
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (exp !== got) begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  // register index i sits at OFS_CCA_HI + 4*i
  task automatic wr(input int i, input logic [7:0] v);
    mac.bus_access(1'b0, OFS_CCA_HI + 8'(4 * i), {24'h000000, v}, rd);
    mdl[i] = v;
  endtask
  task automatic rd_chk(input int i);
    mac.bus_access(1'b1, OFS_CCA_HI + 8'(4 * i), 32'h0, rd);
    chk("register readback", {24'h000000, mdl[i]}, rd);
  endtask
  // mask order: dwell, header start, tick, found, strobe
  task automatic pulse(input logic [4:0] m);
    @(posedge clock_i);
    {dwell, hdr_start, tick, found, strobe} <= m;
    @(posedge clock_i);
    {dwell, hdr_start, tick, found, strobe} <= 5'h00;
    @(negedge clock_i);
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    clock_i = 1'b0;
    forever #20 clock_i = ~clock_i;
  end
  initial begin
    #2000000;
    err_count++;
    conclude();
  end

  // ***************************************
  // scenarios
  // ***************************************
  initial begin
    {dwell, hdr_start, tick, found, strobe} = '0;
    metric = '0;
    strength = '0;
    rx_field = '0;
    err_count = 0;
    num_checks = 0;
    seed = 32'h663a7324;
    mdl = '{RST_CCA_HI, RST_CCA_LO, RST_ED_THR, RST_SFD_TMR, RST_CODE_1M, RST_CODE_2M, RST_CODE_5M5,
            RST_CODE_11M, RST_TX_RATE};
    reset_n_i = 1'b0;
    repeat (4) @(posedge clock_i);
    reset_n_i <= 1'b1;
    for (int i = 0; i < 9; i++) rd_chk(i);
    mac.bus_access(1'b1, 8'h54, 32'h0, rd);
    chk("unmapped read", 32'h0, rd);
    // random contents, then every register read back without aliasing
    for (int i = 0; i < 9; i++) wr(i, rnd());
    for (int i = 0; i < 9; i++) rd_chk(i);
    chk("cca threshold", {17'h0, mdl[0][6:0], mdl[1]}, {17'h0, cca_thr});
    mac.load_codes();
    mdl[4] = 8'h0a;
    mdl[5] = 8'h14;
    mdl[6] = 8'h37;
    mdl[7] = 8'h6e;
    // every selector value, upper bits random and without effect
    for (int s = 0; s < 4; s++) begin
      mdl[8] = {rnd() & 8'hfc} | 8'(s);
      mac.set_rate(mdl[8]);
      @(negedge clock_i);
      chk("tx signal field", {24'h0, mdl[4 + s]}, {24'h0, tx_field});
      rd_chk(8);
    end
    // energy threshold compare, then all ones disables the flag
    for (int n = 0; n < 8; n++) begin
      thr = (n == 7) ? 63 : int'(rnd() % 63);
      wr(2, {rnd() & 8'hc0} | 8'(thr));
      @(posedge clock_i);
      strength <= (n == 7) ? 6'h3f : 6'(rnd());
      repeat (2) @(posedge clock_i);
      @(negedge clock_i);
      chk("energy flag", {31'h0, thr != 63 && int'(strength) >= thr}, {31'h0, ed_flag});
    end
    // quality compare on a dwell, energy term off
    for (int n = 0; n < 6; n++) begin
      wr(1, rnd());
      wr(0, rnd());
      @(posedge clock_i);
      metric <= (n == 0) ? {mdl[0][6:0], mdl[1]} : 15'({rnd(), rnd()});
      pulse(5'b10000);
      qexp = metric >= {mdl[0][6:0], mdl[1]};
      chk("quality pass", {31'h0, qexp}, {31'h0, q_pass});
      chk("cca busy", {31'h0, qexp}, {31'h0, busy});
    end
    // delimiter search timeout after the programmed number of symbols
    for (int n = 0; n < 3; n++) begin
      lim = (n == 0) ? 1 : int'(rnd() % 6) + 2;
      wr(3, 8'(lim));
      pulse(5'b01000);
      chk("searching", 32'h1, {31'h0, searching});
      for (int t = 1; t <= lim; t++) begin
        pulse(5'b00100);
        chk("return to acquisition", {31'h0, t == lim}, {31'h0, to_acq});
      end
      @(negedge clock_i);
      chk("search ended", 32'h0, {31'h0, searching | to_acq});
    end
    // a found delimiter ends the search with no return
    pulse(5'b01000);
    pulse(5'b00100);
    pulse(5'b00010);
    chk("found no return", 32'h0, {31'h0, searching | to_acq});
    // received field classification, each code and a mismatch
    for (int n = 0; n < 6; n++) begin
      @(posedge clock_i);
      rx_field <= (n < 4) ? mdl[4 + n] : ((n == 4) ? 8'h00 : 8'hff);
      pulse(5'b00001);
      chk("rx valid", {31'h0, n < 4}, {31'h0, rx_valid});
      chk("rx rate", (n < 4) ? n : 0, {30'h0, rx_rate});
    end
    // status word after a 5.5 Mbps field; busy echoes the last quality result
    @(posedge clock_i);
    rx_field <= mdl[6];
    pulse(5'b00001);
    mac.bus_access(1'b1, OFS_STATUS, 32'h0, rd);
    chk("status", {27'h0, qexp, 1'b0, 2'h2, 1'b1}, rd);
    conclude();
  end
endmodule // baseband_header_rate_and_cca_config_bench
`default_nettype wire
